/* File: design/ssp_pkg.sv */
package ssp_pkg;

    // Register byte offsets
    localparam logic [3:0] OFF_CONTROL_ONE = 4'h0;
    localparam logic [3:0] OFF_PORT_STATUS = 4'h4;
    localparam logic [3:0] OFF_XFER_BUFFER = 4'h8;
    localparam logic [3:0] OFF_PIN_CONTROL = 4'hc;

    // control_one fields
    localparam int CTL_COLL_BIT = 7;
    localparam int CTL_OVF_BIT  = 6;
    localparam int CTL_EN_BIT   = 5;
    localparam int CTL_POL_BIT  = 4;

    // port_status fields
    localparam int STAT_LATE_BIT = 7;
    localparam int STAT_CKE_BIT  = 6;
    localparam int STAT_FULL_BIT = 0;

    // pin_control fields
    localparam int PIN_SCK_DIR_BIT  = 0;
    localparam int PIN_SDO_DIR_BIT  = 1;
    localparam int PIN_SS_DIR_BIT   = 2;
    localparam int PIN_IRQ_EN_BIT   = 3;
    localparam int PIN_IRQ_FLAG_BIT = 4;

    // Reset values
    localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
    localparam logic [1:0] PORT_STATUS_RST = 2'h0;
    localparam logic [2:0] PIN_DIR_RST     = 3'h7;

    // mode_select codes
    localparam logic [3:0] MODE_M_DIV4  = 4'h0;
    localparam logic [3:0] MODE_M_DIV16 = 4'h1;
    localparam logic [3:0] MODE_M_DIV64 = 4'h2;
    localparam logic [3:0] MODE_M_TMR   = 4'h3;
    localparam logic [3:0] MODE_S_SS    = 4'h4;
    localparam logic [3:0] MODE_S_NOSS  = 4'h5;

    // Bit clock timing: serial clock toggles every half bit period
    localparam int OSC_DIV4     = 4;
    localparam int OSC_DIV16    = 16;
    localparam int OSC_DIV64    = 64;
    localparam logic [5:0] HALF_DIV4  = 6'(OSC_DIV4 / 2);
    localparam logic [5:0] HALF_DIV16 = 6'(OSC_DIV16 / 2);
    localparam logic [5:0] HALF_DIV64 = 6'(OSC_DIV64 / 2);
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] SCK_EDGES     = 5'h10;
    localparam logic [4:0] LAST_TICK     = 5'h11;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} ssp_state_t;

endpackage : ssp_pkg

/* File: design/ssp_port.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Software sets pin directions per master/slave role.
// - Opposite direction bit overrides a pin's function.
// - Master may start a transfer at any time.
// - Master buffer write starts 8-bit exchange immediately.
// - Receive-only master still shifts and loads bytes.
// - Bytes go out MSB first; idle level set.
// - Master clock: osc/4, /16, /64 or timer/2.
// - With edge_select, first bit precedes first edge.
// - Shift out on programmed edge, capture on other.
// - Slave shifts on external clock; flag at last bit.
// - Slave keeps running in sleep; byte wakes device.
// - Select-controlled slave: low select enables, drives out.
// - Select high floats serial_out one clock later.
// - Select high or disable clears bit counter.
// - serial_out as input disables transmission.
// - Master sleep freezes transfer; resumes on wake.
// - Slave shift is free of core; 8 bits flag.
// - Enabled interrupt wakes device; disabled does not.
// - Device reset disables port, aborts transfer.
// - mode_select codes; other codes invalid.
// - Busy write ignored, sets collision; full flag.
// - Slave unread buffer: overflow, new byte dropped.
// - Master sample middle or end; slave uses middle.
module ssp_port
    import ssp_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              clk,           // 10 MHz core clock
    input  wire logic              rst_b,         // Async reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
    input  wire logic              s_axi_awvalid, // Write address valid
    output logic                   s_axi_awready, // Write address ready
    input  wire logic [31:0]       s_axi_wdata,   // Write data
    input  wire logic [3:0]        s_axi_wstrb,   // Write strobes
    input  wire logic              s_axi_wvalid,  // Write data valid
    output logic                   s_axi_wready,  // Write data ready
    output logic [1:0]             s_axi_bresp,   // Write response
    output logic                   s_axi_bvalid,  // Write response valid
    input  wire logic              s_axi_bready,  // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
    input  wire logic              s_axi_arvalid, // Read address valid
    output logic                   s_axi_arready, // Read address ready
    output logic [31:0]            s_axi_rdata,   // Read data
    output logic [1:0]             s_axi_rresp,   // Read response
    output logic                   s_axi_rvalid,  // Read data valid
    input  wire logic              s_axi_rready,  // Read data ready
    input  wire logic              sck_in,        // Serial clock pin level
    output logic                   sck_out,       // Serial clock drive value
    output logic                   sck_oe,        // Serial clock drive enable
    input  wire logic              sdi_in,        // serial_in pin level
    output logic                   sdo_out,       // serial_out drive value
    output logic                   sdo_oe,        // serial_out drive enable
    input  wire logic              ss_n_in,       // Slave select, active low
    input  wire logic              timer_two_tick, // timer_two output pulse
    input  wire logic              sleep_mode,    // Device asleep
    output logic                   wake_req       // Wake request level
);

    if (ADDR_W < 4) begin : g_bad_addr
        $error("ssp_port: ADDR_W must be at least 4");
    end

    function automatic logic is_master(input logic [3:0] m);
        return m <= MODE_M_TMR;
    endfunction : is_master

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return ((a >> 4) == '0) && (a[1:0] == 2'b00);
    endfunction : addr_ok

    // Bus state
    logic              aw_got_reg;
    logic              w_got_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0]        w_data_reg;
    logic              w_strb0_reg;
    // Software-visible bits
    logic       coll_reg, ovf_reg, en_reg, pol_reg;
    logic [3:0] mode_reg;
    logic       late_reg, cke_reg, full_reg;
    logic [7:0] buf_reg;
    logic       dir_sck_reg, dir_sdo_reg, dir_ss_reg, irq_en_reg, irq_flag_reg;
    // Shift engine
    ssp_state_t state_reg;
    logic [4:0] tick_cnt_reg;
    logic [5:0] div_cnt_reg;
    logic [7:0] tx_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic       sck_prev_reg;

    logic       aw_hs, w_hs, wr_fire, ar_hs, wr_ok;
    logic       wr_ctl, wr_pin, wr_stat, wr_buf, rd_buf;
    logic       master_mode, slave_mode, mode_ok, ss_block, busy;
    logic       start_master, collision, load_tx;
    logic       half_tick, m_out, m_take, m_done;
    logic       s_edge, s_lead, s_trail, s_out, s_take, s_done;
    logic [4:0] t;
    logic [5:0] half_len;
    logic [7:0] rx_next;
    logic       done, take_byte, overflow;

    assign aw_hs   = s_axi_awvalid && s_axi_awready;
    assign w_hs    = s_axi_wvalid && s_axi_wready;
    assign ar_hs   = s_axi_arvalid && s_axi_arready;
    assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
    assign wr_ok   = wr_fire && w_strb0_reg && addr_ok(aw_addr_reg);
    assign wr_ctl  = wr_ok && (aw_addr_reg[3:0] == OFF_CONTROL_ONE);
    assign wr_stat = wr_ok && (aw_addr_reg[3:0] == OFF_PORT_STATUS);
    assign wr_buf  = wr_ok && (aw_addr_reg[3:0] == OFF_XFER_BUFFER);
    assign wr_pin  = wr_ok && (aw_addr_reg[3:0] == OFF_PIN_CONTROL);
    assign rd_buf  = ar_hs && addr_ok(s_axi_araddr)
                     && (s_axi_araddr[3:0] == OFF_XFER_BUFFER);

    // Reserved codes leave the port idle
    assign mode_ok     = mode_reg <= MODE_S_NOSS;
    assign master_mode = is_master(mode_reg);
    assign slave_mode  = mode_ok && !is_master(mode_reg);
    // A select pin turned to output is treated as deselected
    assign ss_block    = (mode_reg == MODE_S_SS) && (ss_n_in || !dir_ss_reg);
    assign busy = (state_reg == ST_MASTER)
                  || ((state_reg == ST_SLAVE) && (bit_cnt_reg != 4'h0));
    assign collision    = wr_buf && busy;
    assign start_master = wr_buf && en_reg && master_mode
                          && (state_reg == ST_IDLE);
    assign load_tx      = wr_buf && !busy;

    always_comb begin
        unique case (mode_reg)
            MODE_M_DIV16: half_len = HALF_DIV16;
            MODE_M_DIV64: half_len = HALF_DIV64;
            default:      half_len = HALF_DIV4;
        endcase
    end

    // Sleep stops the master bit clock where it stands
    assign half_tick = (state_reg == ST_MASTER) && !sleep_mode
                       && ((mode_reg == MODE_M_TMR) ? timer_two_tick
                                                    : (div_cnt_reg == half_len - 6'h1));
    assign t = tick_cnt_reg + 5'h1;
    // Output on one edge parity, sample on the other or at end of bit
    assign m_out = half_tick && (cke_reg ? (!t[0] && t < 5'h0f)
                                         : (t[0] && t < SCK_EDGES));
    assign m_take = half_tick && (late_reg
                   ? (cke_reg ? (!t[0] && t <= SCK_EDGES) : (t[0] && t >= 5'h03))
                   : (cke_reg ? (t[0] && t < SCK_EDGES) : (!t[0] && t <= SCK_EDGES)));
    assign m_done = half_tick && (t == LAST_TICK);

    // Slave edges come only from the external clock pin; sleep never gates them
    assign s_edge  = (state_reg == ST_SLAVE) && dir_sck_reg && !ss_block
                     && (sck_in != sck_prev_reg);
    assign s_lead  = s_edge && (sck_in != pol_reg);
    assign s_trail = s_edge && (sck_in == pol_reg);
    assign s_out   = cke_reg ? s_trail : s_lead;
    assign s_take  = cke_reg ? s_lead : s_trail;
    assign s_done  = s_take && (bit_cnt_reg == BITS_PER_BYTE - 4'h1);

    assign rx_next   = (m_take || s_take) ? {shift_reg[6:0], sdi_in} : shift_reg;
    assign done      = m_done || s_done;
    assign overflow  = s_done && full_reg && !rd_buf;
    assign take_byte = done && !overflow;

    // Write channel
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= 8'h00;
            w_strb0_reg   <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got_reg    <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_got_reg    <= 1'b1;
                w_data_reg   <= s_axi_wdata[7:0];
                w_strb0_reg  <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata   <= 32'h0000_0000;
            if (addr_ok(s_axi_araddr)) begin
                unique case (s_axi_araddr[3:0])
                    OFF_CONTROL_ONE: s_axi_rdata[7:0] <= {coll_reg, ovf_reg, en_reg,
                                                          pol_reg, mode_reg};
                    OFF_PORT_STATUS: s_axi_rdata[7:0] <= {late_reg, cke_reg, 5'h00, full_reg};
                    OFF_XFER_BUFFER: s_axi_rdata[7:0] <= buf_reg;
                    OFF_PIN_CONTROL: s_axi_rdata[7:0] <= {3'h0, irq_flag_reg, irq_en_reg,
                                                          dir_ss_reg, dir_sdo_reg,
                                                          dir_sck_reg};
                    default:         s_axi_rdata[7:0] <= 8'h00;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Configuration; hardware sets of sticky flags win over clears
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {coll_reg, ovf_reg, en_reg, pol_reg, mode_reg} <= CONTROL_ONE_RST;
            {late_reg, cke_reg} <= PORT_STATUS_RST;
            {dir_ss_reg, dir_sdo_reg, dir_sck_reg} <= PIN_DIR_RST;
            irq_en_reg   <= 1'b0;
            irq_flag_reg <= 1'b0;
            full_reg     <= 1'b0;
        end else begin
            if (wr_ctl) begin
                en_reg   <= w_data_reg[CTL_EN_BIT];
                pol_reg  <= w_data_reg[CTL_POL_BIT];
                mode_reg <= w_data_reg[3:0];
            end
            coll_reg <= collision || (wr_ctl ? w_data_reg[CTL_COLL_BIT] : coll_reg);
            ovf_reg  <= overflow || (wr_ctl ? w_data_reg[CTL_OVF_BIT] : ovf_reg);
            if (wr_stat) begin
                late_reg <= w_data_reg[STAT_LATE_BIT];
                cke_reg <= w_data_reg[STAT_CKE_BIT];
            end
            if (wr_pin) begin
                dir_sck_reg <= w_data_reg[PIN_SCK_DIR_BIT];
                dir_sdo_reg <= w_data_reg[PIN_SDO_DIR_BIT];
                dir_ss_reg  <= w_data_reg[PIN_SS_DIR_BIT];
                irq_en_reg  <= w_data_reg[PIN_IRQ_EN_BIT];
            end
            irq_flag_reg <= done
                            || (wr_pin ? w_data_reg[PIN_IRQ_FLAG_BIT] : irq_flag_reg);
            full_reg <= take_byte || (full_reg && !rd_buf);
        end
    end

    // Transfer buffer: a write while not busy loads it, a finished byte replaces it unless it overflows
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            buf_reg <= 8'h00;
        end else if (take_byte) begin
            buf_reg <= rx_next;
        end else if (load_tx) begin
            buf_reg <= w_data_reg;
        end
    end

    // Shift engine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= ST_IDLE;
            tick_cnt_reg <= 5'h00;
            div_cnt_reg  <= 6'h00;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
        end else if (!en_reg || !mode_ok) begin
            state_reg    <= ST_IDLE;
            tick_cnt_reg <= 5'h00;
            div_cnt_reg  <= 6'h00;
            bit_cnt_reg  <= 4'h0;
        end else begin
            shift_reg <= rx_next;
            unique case (state_reg)
                ST_IDLE: begin
                    if (slave_mode) begin
                        state_reg <= ST_SLAVE;
                    end else if (start_master) begin
                        state_reg    <= ST_MASTER;
                        tick_cnt_reg <= 5'h00;
                        div_cnt_reg  <= 6'h00;
                    end
                end
                ST_MASTER: begin
                    if (half_tick) begin
                        div_cnt_reg  <= 6'h00;
                        tick_cnt_reg <= m_done ? 5'h00 : t;
                        if (m_done) begin
                            state_reg <= ST_IDLE;
                        end
                    end else if (!sleep_mode) begin
                        div_cnt_reg <= div_cnt_reg + 6'h1;
                    end
                end
                ST_SLAVE: begin
                    if (!slave_mode) begin
                        state_reg <= ST_IDLE;
                    end
                    if (ss_block) begin
                        bit_cnt_reg <= 4'h0;
                    end else if (s_take) begin
                        bit_cnt_reg <= s_done ? 4'h0 : bit_cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // Transmit path, MSB first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_reg  <= 8'h00;
            sdo_out <= 1'b0;
        end else if (load_tx) begin
            // Edge_select puts bit 7 out before the first clock edge
            sdo_out <= w_data_reg[7];
            tx_reg  <= cke_reg ? {w_data_reg[6:0], 1'b0} : w_data_reg;
        end else if (m_out || s_out) begin
            sdo_out <= tx_reg[7];
            tx_reg  <= {tx_reg[6:0], 1'b0};
        end
    end

    // Pin drivers; enables settle one clock after their cause
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_out      <= 1'b0;
            sck_oe       <= 1'b0;
            sdo_oe       <= 1'b0;
            sck_prev_reg <= 1'b0;
            wake_req     <= 1'b0;
        end else begin
            sck_prev_reg <= sck_in;
            if (state_reg != ST_MASTER) begin
                sck_out <= pol_reg;
            end else if (half_tick && t <= SCK_EDGES) begin
                sck_out <= !sck_out;
            end
            sck_oe <= en_reg && master_mode && !dir_sck_reg;
            sdo_oe <= en_reg && mode_ok && !dir_sdo_reg
                      && !ss_block;
            // Slave logic runs on the core clock, which stays up in sleep
            wake_req <= irq_flag_reg && irq_en_reg;
        end
    end

    a_sck_idle_level: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg != ST_MASTER) |=> (sck_out == $past(pol_reg)))
        else $error("serial clock not at idle level");

    a_master_start: assert property (@(posedge clk) disable iff (!rst_b)
        start_master && mode_ok |=> (state_reg == ST_MASTER) && (tick_cnt_reg == 5'h00))
        else $error("master transfer did not start");

    a_collision_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        collision && !done |=> coll_reg && (buf_reg == $past(buf_reg)))
        else $error("busy write not flagged or not ignored");

    a_byte_full_flag: assert property (@(posedge clk) disable iff (!rst_b)
        take_byte |=> full_reg && (buf_reg == $past(rx_next)))
        else $error("completed byte not loaded");

    a_slave_overflow: assert property (@(posedge clk) disable iff (!rst_b)
        overflow |=> ovf_reg && (buf_reg == $past(buf_reg)))
        else $error("overflow not handled");

    a_select_release: assert property (@(posedge clk) disable iff (!rst_b)
        ss_block && en_reg |=> !sdo_oe && (bit_cnt_reg == 4'h0))
        else $error("select high left output driven or count set");

    a_disable_reset: assert property (@(posedge clk) disable iff (!rst_b)
        !en_reg |=> (state_reg == ST_IDLE) && (bit_cnt_reg == 4'h0) && !sck_oe)
        else $error("disabled port not held idle");

    a_sleep_freeze: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_MASTER) && sleep_mode && en_reg
        |=> $stable(tick_cnt_reg) && $stable(div_cnt_reg))
        else $error("master advanced during sleep");

    a_first_bit_ready: assert property (@(posedge clk) disable iff (!rst_b)
        start_master && cke_reg
        |=> (sdo_out == $past(w_data_reg[7])) && (sck_out == $past(pol_reg)))
        else $error("first bit not presented before clock edge");

    a_wake_gate: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (wake_req == $past(irq_flag_reg && irq_en_reg)))
        else $error("wake request does not follow enabled flag");

endmodule : ssp_port

/* File: dv/ssp_spi_peer.sv */
`timescale 1ns/1ps
module ssp_spi_peer (
    input  wire logic       sck,     // Serial clock seen on the wire
    input  wire logic       mosi,    // Data from the port
    input  wire logic [7:0] tx_byte, // Byte handed back to the port
    output logic            miso,    // Data to the port
    output logic [7:0]      rx_byte  // Bits captured from the port
);
    int cnt = 0;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    // Shift out on the idle-to-active edge, capture on the other one
    always @(posedge sck) miso <= tx_byte[7 - cnt];
    always @(negedge sck) begin
        rx_byte <= {rx_byte[6:0], mosi};
        cnt <= (cnt + 1) % 8;
    end
endmodule : ssp_spi_peer

/* File: dv/sync_serial_spi_port_tb.sv */
`timescale 1ns/1ps
module sync_serial_spi_port_tb
    import ssp_pkg::*;
;
    logic        clk = 0, rst_b = 0, sleep = 0, tick = 0;
    logic [3:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        sck_out, sck_oe, sdo_out, sdo_oe, wake, miso;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  ptx = 0, prx;
    int          errors = 0, n_compared = 0, cyc = 0;
    wire         sck_w = sck_oe ? sck_out : 1'b0;

    always #50 clk = ~clk;
    // Timer output event every fourth cycle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 4 == 0);
    end

    ssp_port dut_u (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(miso),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n_in(1'b1), .timer_two_tick(tick),
        .sleep_mode(sleep), .wake_req(wake));

    ssp_spi_peer peer_u (.sck(sck_w), .mosi(sdo_out), .tx_byte(ptx), .miso(miso),
        .rx_byte(prx));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        // Each channel is released on its own handshake edge
        do begin
            @(posedge clk);
            if (awready === 1'b1 && !aw_ok) begin
                aw_ok = 1;
                awvalid <= 0;
            end
            if (wready === 1'b1 && !w_ok) begin
                w_ok = 1;
                wvalid <= 0;
            end
        end while (!(aw_ok && w_ok));
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 0;
    endtask : wr

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask : rd_reg

    task automatic close_out;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1;
        rd_reg(OFF_CONTROL_ONE, rd, rs);
        chk(rd, 32'h0);
        rd_reg(OFF_PIN_CONTROL, rd, rs);
        chk(rd, 32'h7);
        rd_reg(4'h2, rd, rs);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(OFF_PIN_CONTROL, 8'h08);
        // Every master clock source, each with a sleep in mid-byte
        for (int m = 0; m < 4; m++) begin
            ptx <= 8'(8'h3c + m);
            wr(OFF_PORT_STATUS, (m % 2 == 1) ? 8'h80 : 8'h00);
            wr(OFF_CONTROL_ONE, 8'(8'h20 | m));
            wr(OFF_XFER_BUFFER, 8'(8'ha5 + m));
            wr(OFF_XFER_BUFFER, 8'hff);
            sleep <= 1;
            repeat (40) @(posedge clk);
            sleep <= 0;
            rd = 0;
            for (int i = 0; i < 400 && rd[0] !== 1'b1; i++) rd_reg(OFF_PORT_STATUS, rd, rs);
            chk({31'h0, rd[0]}, 32'h1);
            rd_reg(OFF_XFER_BUFFER, rd, rs);
            chk(rd, {24'h0, 8'(8'h3c + m)});
            chk({24'h0, prx}, {24'h0, 8'(8'ha5 + m)});
            rd_reg(OFF_PORT_STATUS, rd, rs);
            chk({31'h0, rd[0]}, 32'h0);
            rd_reg(OFF_CONTROL_ONE, rd, rs);
            chk(rd, 32'(8'ha0 | m));
            rd_reg(OFF_PIN_CONTROL, rd, rs);
            chk(rd, 32'h18);
            chk({31'h0, wake}, 32'h1);
            wr(OFF_PIN_CONTROL, 8'h08);
            wr(OFF_CONTROL_ONE, 8'h00);
            chk({31'h0, wake}, 32'h0);
        end
        close_out();
    end

    // Slowest source needs about 544 cycles a byte
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule : sync_serial_spi_port_tb
